// ### acr_pkg.sv
// Purpose: Shared constants and types for the converter read interface.
// Assumes: Single 25 MHz clock, synchronous active-low reset.
// Notes:   Conversion time is expressed in ns and converted to cycles.
// Operation
// - Select, read and byte select low start a conversion; busy drops.
// - During a conversion the pins still show the preceding result.
// - At conversion end latch updates, pins show it, then busy rises.
// - Byte access uses only the eight lower pins over two reads.
// - High byte read starts nothing; lower pins give zero nibble, MSBs.
// - The four MSBs always appear on the upper four pins when driven.
// - Wait-style byte read delivers bits 7 to 0 after conversion ends.
// - Pipelined read starts conversion and returns the previous result.
// - Next pipelined read returns the new result and starts another.
// - Pipelined third read with byte select high gives the new MSBs.
// - A high byte read never asserts busy.
// - Start only while select, read and byte select are all low.
// - Start conditions are ignored while a conversion runs.
package acr_pkg;

  localparam int          DATA_W        = 12;
  localparam int          BYTE_W        = 8;
  localparam int          MSB_W         = 4;
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          CONV_TIME_NS  = 5000;
  localparam int          CONV_CYCLES   =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W         = 8;
  localparam logic [11:0] RESULT_RST    = 12'h000;
  localparam logic [3:0]  NIBBLE_LOW    = 4'h0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_FINISH
  } acr_state_e;

endpackage : acr_pkg

// ### acr_conv_if.sv
// Purpose: Carrier between read control and conversion core.
// Assumes: Both ends on ref_clk.
// Notes:   start and done are one-cycle pulses.
`timescale 1ns/1ns
interface acr_conv_if;
  import acr_pkg::*;

  logic              start;
  logic              done;
  logic [DATA_W-1:0] result;

  modport ctrl (output start, input done, input result);
  modport core (input start, output done, output result);

endinterface : acr_conv_if

// ### acr_sar_core.sv
// Purpose: Conversion timing core; captures the sample at conversion end.
// Assumes: Start arrives only while idle.
// Notes:   Analog path is replaced by a synchronous sample input.
`timescale 1ns/1ns
module acr_sar_core
  import acr_pkg::*;
#(
  parameter int CYCLES = CONV_CYCLES
)
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // Converted value from the analog front end
  input  wire logic [DATA_W-1:0] sampleData,
  // Link to read control
  acr_conv_if.core               conv
);

  typedef struct packed {
    logic              running;
    logic [CNT_W-1:0]  count;
    logic              done;
    logic [DATA_W-1:0] result;
  } acr_core_s;

  acr_core_s coreFf;
  acr_core_s nxt_coreFf;

  always_comb
  begin
    nxt_coreFf      = coreFf;
    nxt_coreFf.done = 1'b0;
    if (!coreFf.running)
    begin
      if (conv.start)
      begin
        nxt_coreFf.running = 1'b1;
        nxt_coreFf.count   = CNT_W'(CYCLES - 1);
      end
    end
    else if (coreFf.count == '0)
    begin
      nxt_coreFf.running = 1'b0;
      nxt_coreFf.done    = 1'b1;
      nxt_coreFf.result  = sampleData;
    end
    else
    begin
      nxt_coreFf.count = coreFf.count - 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      coreFf <= '{running: 1'b0, count: '0, done: 1'b0, result: RESULT_RST};
    end
    else
    begin
      coreFf <= nxt_coreFf;
    end
  end

  assign conv.done   = coreFf.done;
  assign conv.result = coreFf.result;

endmodule : acr_sar_core

// ### adc_conversion_read_interface.sv
// Purpose: Read strobe decode, conversion control and output data mux.
// Assumes: Host strobes are synchronous to ref_clk.
// Notes:   Wait-style and pipelined use differ only in host behaviour.
`timescale 1ns/1ns
module adc_conversion_read_interface
  import acr_pkg::*;
#(
  parameter int CYCLES = CONV_CYCLES
)
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // Host strobes
  input  wire logic              selectN,
  input  wire logic              readN,
  input  wire logic              high_byte_select,
  // Converted value from the analog front end
  input  wire logic [DATA_W-1:0] sampleData,
  // Data pins, split into level and enable
  output logic      [DATA_W-1:0] output_pins,
  output logic                   outputPinsEn,
  // Status
  output logic                   busyN
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    acr_state_e        state;
    logic              startCondPrev;
    logic [DATA_W-1:0] result_bits;
    logic [DATA_W-1:0] pins;
    logic              pinsEn;
    logic              busyN;
  } acr_ctrl_s;

  acr_ctrl_s ctrlFf;
  acr_ctrl_s nxt_ctrlFf;

  acr_conv_if conv ();

  logic startCond;
  logic readActive;
  logic startPulse;

  ////////////////////////////////////////////////////////////////////////////
  // Pin mux

  function automatic logic [DATA_W-1:0] pinMux(
    input logic [DATA_W-1:0] latched,
    input logic              highByte
  );
    logic [DATA_W-1:0] word;
    word = latched;
    // Upper pins carry the MSBs whatever the byte select says
    word[DATA_W-1 -: MSB_W] = latched[DATA_W-1 -: MSB_W];
    if (highByte)
    begin
      // Zero nibble above the MSBs on the lower byte
      word[BYTE_W-1 -: MSB_W] = NIBBLE_LOW;
      word[MSB_W-1:0]         = latched[DATA_W-1 -: MSB_W];
    end
    else
    begin
      // Low byte carries bits 7..0, also valid as full word
      word[BYTE_W-1:0] = latched[BYTE_W-1:0];
    end
    return word;
  endfunction : pinMux

  // Busy stays low through FINISH so it cannot rise before the pins do
  function automatic logic busyLevel(
    input acr_state_e nowState,
    input acr_state_e nextState
  );
    return (nowState == ST_IDLE) && (nextState == ST_IDLE);
  endfunction : busyLevel

  ////////////////////////////////////////////////////////////////////////////
  // Strobe decode

  assign readActive = !selectN && !readN;
  // All three low; byte select high blocks the start
  assign startCond  = readActive && !high_byte_select;

  // Edge of the start condition: a wait-style read still held after the
  // conversion ends must not retrigger a second conversion.
  assign startPulse = startCond && !ctrlFf.startCondPrev &&
                      (ctrlFf.state == ST_IDLE);

  assign conv.start = startPulse;

  ////////////////////////////////////////////////////////////////////////////
  // Control

  // Cycle walk of one conversion, edge E takes the start:
  //   E           state to CONV, busy drops, pins register the old word
  //   E+CYCLES    core captures sampleData and pulses done
  //   E+CYCLES+1  latch takes the new word, state to FINISH
  //   E+CYCLES+2  pins register the new word, state back to IDLE
  //   E+CYCLES+3  busy rises
  // A host that waits on busy therefore never takes a stale word.

  always_comb
  begin
    nxt_ctrlFf               = ctrlFf;
    nxt_ctrlFf.startCondPrev = startCond;
    case (ctrlFf.state)
      ST_IDLE:
      begin
        if (startPulse)
        begin
          nxt_ctrlFf.state = ST_CONV;
        end
      end
      ST_CONV:
      begin
        // Latch still holds the old result meanwhile
        if (conv.done)
        begin
          nxt_ctrlFf.result_bits = conv.result;
          nxt_ctrlFf.state       = ST_FINISH;
        end
      end
      ST_FINISH:
      begin
        nxt_ctrlFf.state = ST_IDLE;
      end
      default:
      begin
        nxt_ctrlFf.state = ST_IDLE;
      end
    endcase

    // Pins follow the latch, so old data shows while converting
    nxt_ctrlFf.pins   = ctrlFf.pinsEn || readActive ?
                        pinMux(ctrlFf.result_bits, high_byte_select) :
                        RESULT_RST;
    nxt_ctrlFf.pinsEn = readActive;

    // Busy rises one cycle after the new word reaches the pins; a high
    // byte read never starts, so busy stays high for it.
    nxt_ctrlFf.busyN  = busyLevel(ctrlFf.state,
                                  nxt_ctrlFf.state);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      ctrlFf <= '{state:         ST_IDLE,
                  startCondPrev: 1'b0,
                  result_bits:   RESULT_RST,
                  pins:          RESULT_RST,
                  pinsEn:        1'b0,
                  busyN:         1'b1};
    end
    else
    begin
      ctrlFf <= nxt_ctrlFf;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion core

  acr_sar_core #(
    .CYCLES (CYCLES)
  ) u_core (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .sampleData (sampleData),
    .conv       (conv.core)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Pipelined and wait-style reads share this path: the first read shows
  // the previous word, as does any read before conversion end; reads after it show the new one.
  assign output_pins  = ctrlFf.pins;
  assign outputPinsEn = ctrlFf.pinsEn;
  assign busyN        = ctrlFf.busyN;

endmodule : adc_conversion_read_interface

// ### acr_chk.sv
// Purpose: Port checks for the converter read interface.
// Assumes: Strobes change away from the rising edge.
// Notes:   Busy length follows the CYCLES parameter.
`timescale 1ns/1ns
module acr_chk
  import acr_pkg::*;
#(
  parameter int CYCLES = CONV_CYCLES
)
(
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              reset_n,
  // Host side
  input wire logic              selectN,
  input wire logic              readN,
  input wire logic              high_byte_select,
  input wire logic [DATA_W-1:0] sampleData,
  // Device side
  input wire logic [DATA_W-1:0] output_pins,
  input wire logic              outputPinsEn,
  input wire logic              busyN
);
  // Busy reads low from the edge after the start through start plus CYCLES+3
  localparam int LOW_M1 = CYCLES + 2;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  AST_EN: assert property (
    outputPinsEn == $past(!selectN && !readN))
    else $error("enable wrong");
  AST_START: assert property (busyN && !selectN && !readN &&
    !high_byte_select && $past(selectN || readN) |=> !busyN)
    else $error("no start");
  AST_HB_IDLE: assert property (busyN && high_byte_select |=> busyN)
    else $error("high byte started");
  AST_UNSEL: assert property (busyN && (selectN || readN) |=> busyN)
    else $error("start unselected");
  AST_BUSY_LEN: assert property ($fell(busyN) |->
    ##LOW_M1 (!busyN ##1 busyN))
    else $error("busy length");
  AST_NEW_DATA: assert property ($rose(busyN) && outputPinsEn &&
    !$past(high_byte_select) |-> output_pins == $past(sampleData, 4))
    else $error("new word");
  AST_HB_FMT: assert property (outputPinsEn && $past(high_byte_select)
    |-> output_pins[7:0] == {4'h0, output_pins[11:8]})
    else $error("high byte format");
  AST_OLD_DATA: assert property ($fell(busyN) && outputPinsEn |=>
    outputPinsEn |-> $stable(output_pins))
    else $error("old word lost");
endmodule : acr_chk

bind adc_conversion_read_interface acr_chk #(.CYCLES(CYCLES)) i_acr_chk
  (.ref_clk(ref_clk), .reset_n(reset_n), .selectN(selectN),
   .readN(readN), .high_byte_select(high_byte_select),
   .sampleData(sampleData), .output_pins(output_pins),
   .outputPinsEn(outputPinsEn), .busyN(busyN));

// ### acr_host.sv
// Purpose: Host bus model driving select and read strobes.
// Assumes: Strobes change on the falling edge only.
// Notes:   A stalled read holds its strobes while busy is low.
`timescale 1ns/1ns
module acr_host
  import acr_pkg::*;
(
  // Clock and device outputs
  input  wire logic              ref_clk,
  input  wire logic              busyN,
  input  wire logic [DATA_W-1:0] output_pins,
  // Strobes
  output logic                   selectN,
  output logic                   readN,
  output logic                   high_byte_select,
  // Captured word
  output logic                   got,
  output logic [DATA_W-1:0]      data,
  output logic                   timedOut
);
  initial
  begin
    {selectN, readN, high_byte_select} = 3'h6;
    {got, timedOut} = 2'h0;
  end
  task automatic read_word(input logic hb, input logic stall);
    int n;
    @(negedge ref_clk);
    {selectN, readN, high_byte_select} = {2'h0, hb};
    repeat (2) @(negedge ref_clk);
    n = 0;
    while (stall && !busyN && n < 400)
    begin
      @(negedge ref_clk);
      n++;
    end
    timedOut = (n >= 400);
    // Taken at once after busy, well inside the acquire window
    data = output_pins;
    got = 1'b1;
    {selectN, readN} = 2'h3;
    @(negedge ref_clk);
    got = 1'b0;
  endtask : read_word
endmodule : acr_host

// ### adc_conversion_read_interface_tb.sv
// Purpose: Self-checking bench for the converter read interface.
// Assumes: Short conversion count for run time.
// Notes:   Expected words queue up in issue order.
`timescale 1ns/1ns
module adc_conversion_read_interface_tb;
  import acr_pkg::*;
  localparam int CYC = 4;
  logic              ref_clk, reset_n, selectN, readN, hbSel;
  logic              got, timedOut, pinsEn, busyN;
  logic [DATA_W-1:0] sampleData, pins, data, prev, expV;
  logic [DATA_W-1:0] expQ[$];
  logic [31:0]       seed;
  int                failures, check_count;
  adc_conversion_read_interface #(.CYCLES(CYC))
    i_adc_conversion_read_interface (.ref_clk(ref_clk),
    .reset_n(reset_n), .selectN(selectN), .readN(readN),
    .high_byte_select(hbSel), .sampleData(sampleData),
    .output_pins(pins), .outputPinsEn(pinsEn), .busyN(busyN));
  acr_host i_acr_host (.ref_clk(ref_clk), .busyN(busyN),
    .output_pins(pins), .selectN(selectN), .readN(readN),
    .high_byte_select(hbSel), .got(got), .data(data),
    .timedOut(timedOut));
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  function automatic logic [DATA_W-1:0] hbw(input logic [DATA_W-1:0] v);
    return {v[11:8], 4'h0, v[11:8]};
  endfunction : hbw
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift
  task automatic next_sample();
    seed       = xorshift(seed);
    sampleData = seed[DATA_W-1:0];
  endtask : next_sample
  task automatic rd(input logic hb, stall, input logic [DATA_W-1:0] e);
    expQ.push_back(e);
    i_acr_host.read_word(hb, stall);
  endtask : rd
  task automatic complete_run();
    if (failures == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic check_word(input string what, input logic [DATA_W-1:0] want,
                            input logic [DATA_W-1:0] seen);
    check_count++;
    if (seen !== want)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask : check_word
  task automatic check_bit(input string what, input logic want, seen);
    check_count++;
    if (seen !== want)
    begin
      failures++;
      $display("wrong value %s expected %b seen %b", what, want, seen);
    end
  endtask : check_bit
  // Flops settle by non-blocking update, so this edge sees the old values
  always @(posedge ref_clk)
  begin
    if (got === 1'b1)
    begin
      expV = expQ.pop_front();
      check_word("output_pins", expV, data);
      check_bit("outputPinsEn", 1'b1, pinsEn);
      if (hbSel === 1'b1)
        check_bit("busyN", 1'b1, busyN);
    end
  end
  always @(posedge timedOut)
  begin
    failures++;
    complete_run();
  end
  initial
  begin
    {reset_n, sampleData, seed} = {1'b0, 12'h000, 32'h0000f387};
    {failures, check_count} = {32'h0, 32'h0};
    repeat (16) @(negedge ref_clk);
    reset_n = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      next_sample();
      rd(1'b0, 1'b1, sampleData);
      rd(1'b1, 1'b0, hbw(sampleData));
    end
    for (int i = 0; i < 3; i++)
    begin
      prev = sampleData;
      next_sample();
      rd(1'b0, 1'b0, prev);
      rd(1'b0, 1'b0, prev);
      repeat (CYC + 4) @(negedge ref_clk);
      rd(1'b1, 1'b0, hbw(sampleData));
    end
    rd(1'b0, 1'b0, sampleData);
    complete_run();
  end
endmodule : adc_conversion_read_interface_tb
